// ### rtl/prwdt_top.sv
// Port-read watchdog timer top level
module prwdt_top
	import prwdt_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = PRWDT_TICK_CYCLES // Cycles per second
)(
	input  wire logic                    sys_clk_i,                   // System clock 10 MHz
	input  wire logic                    reset_n_i,                   // Sync reset, active low
	input  wire logic [PRWDT_ADDR_W-1:0] io_addr_i,                   // I/O address
	input  wire logic                    io_rd_i,                     // I/O read strobe
	input  wire logic                    io_wr_i,                     // I/O write strobe
	output logic      [7:0]              io_rdata_o,                  // Read data, undefined use
	input  wire logic [1:0]              timeout_action_jumper_i,     // Action select
	input  wire logic [2:0]              timeout_period_jumper_i,     // Period select
	output logic                         sys_reset_o,                 // Timeout reset pulse
	output logic                         nmi_o,                       // Timeout NMI pulse
	output logic                         armed_o                      // Timer armed
);

	//------------------------------------------------------------------
	// Elaboration checks
	//------------------------------------------------------------------
	if (TICK_CYCLES < 1 || TICK_CYCLES > 32'h00FFFFFF) begin : g_bad_tick
		$error("TICK_CYCLES out of range");
	end

	//------------------------------------------------------------------
	// Period lookup
	//------------------------------------------------------------------
	function automatic logic [7:0] prwdt_period_sec(input logic [2:0] code);
		case (code)
			PRWDT_JP_1S:   prwdt_period_sec = PRWDT_SEC_1;
			PRWDT_JP_2S:   prwdt_period_sec = PRWDT_SEC_2;
			PRWDT_JP_10S:  prwdt_period_sec = PRWDT_SEC_10;
			PRWDT_JP_20S:  prwdt_period_sec = PRWDT_SEC_20;
			PRWDT_JP_110S: prwdt_period_sec = PRWDT_SEC_110;
			PRWDT_JP_220S: prwdt_period_sec = PRWDT_SEC_220;
			// Undocumented codes fall back to the shortest, safest period
			default:       prwdt_period_sec = PRWDT_SEC_1;
		endcase
	endfunction : prwdt_period_sec

	//------------------------------------------------------------------
	// Port decode
	//------------------------------------------------------------------
	prwdt_if cmd_if ();

	prwdt_decode u_decode (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.io_addr_i (io_addr_i),
		.io_rd_i   (io_rd_i),
		.io_wr_i   (io_wr_i),
		.cmd       (cmd_if.dec)
	);

	//------------------------------------------------------------------
	// Timer state
	//------------------------------------------------------------------
	localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

	prwdt_state_t state;
	prwdt_state_t next_state;
	logic [23:0]  tick_cnt;
	logic [23:0]  next_tick_cnt;
	logic [7:0]   sec_cnt;
	logic [7:0]   next_sec_cnt;
	logic         sys_reset;
	logic         next_sys_reset;
	logic         nmi;
	logic         next_nmi;
	logic         expired;

	always_comb begin
		next_state     = state;
		next_tick_cnt  = tick_cnt;
		next_sec_cnt   = sec_cnt;
		next_sys_reset = 1'b0;
		next_nmi       = 1'b0;
		expired        = 1'b0;
		case (state)
			PRWDT_ST_IDLE: begin
				if (cmd_if.arm_kick && !cmd_if.disarm) begin
					next_state    = PRWDT_ST_ARMED;
					next_tick_cnt = 24'h000000;
					next_sec_cnt  = 8'h00;
				end
			end
			PRWDT_ST_ARMED: begin
				if (cmd_if.disarm) begin
					next_state = PRWDT_ST_IDLE;
				end else if (cmd_if.arm_kick) begin
					next_tick_cnt = 24'h000000;
					next_sec_cnt  = 8'h00;
				end else if (tick_cnt == TICK_LAST) begin
					next_tick_cnt = 24'h000000;
					next_sec_cnt  = sec_cnt + 8'h01;
					// Jumper read live, so a change takes effect at the next second
					if ((sec_cnt + 8'h01) >= prwdt_period_sec(timeout_period_jumper_i)) begin
						expired      = 1'b1;
						next_state   = PRWDT_ST_IDLE; // One action per timeout, then rearm needed
						next_sec_cnt = 8'h00;
					end
				end else begin
					next_tick_cnt = tick_cnt + 24'h000001;
				end
			end
			default: begin
				next_state = PRWDT_ST_IDLE;
			end
		endcase
		if (expired) begin
			next_sys_reset = (timeout_action_jumper_i == PRWDT_ACT_RESET);
			next_nmi       = (timeout_action_jumper_i == PRWDT_ACT_NMI);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			state     <= PRWDT_ST_IDLE;
			tick_cnt  <= 24'h000000;
			sec_cnt   <= 8'h00;
			sys_reset <= 1'b0;
			nmi       <= 1'b0;
		end else begin
			state     <= next_state;
			tick_cnt  <= next_tick_cnt;
			sec_cnt   <= next_sec_cnt;
			sys_reset <= next_sys_reset;
			nmi       <= next_nmi;
		end
	end

	assign sys_reset_o = sys_reset;
	assign nmi_o       = nmi;
	assign armed_o     = (state == PRWDT_ST_ARMED);
	assign io_rdata_o  = PRWDT_READ_DATA;

endmodule : prwdt_top

// ### rtl/prwdt_pkg.sv
// Constants and types for the port-read watchdog timer
//----------------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------------
// Notes on behaviour
// - A host I/O read of the arm/kick port arms the timer and starts counting.
// - A host I/O read of the disarm port disarms the timer and stops counting.
// - A read of the arm/kick port while armed counts as a refresh.
// - Every refresh restarts the period; the host must refresh before it elapses.
// - Reaching the period unrefreshed raises system reset or NMI, per action jumper.
// - Action jumper: reset (default), NMI, or off meaning no action ever.
// - Period jumper selects 1, 2, 10, 20, 110 or 220 seconds; default 1 s.
// - After power-on the timer is disarmed and produces no action.
// - Control uses exactly two I/O ports, by read cycles; read data is undefined.
package prwdt_pkg;

	localparam logic [15:0] PRWDT_DISARM_PORT_ADDR = 16'h0045;
	localparam logic [15:0] PRWDT_ARM_KICK_PORT_ADDR = 16'h0443;
	localparam int unsigned PRWDT_ADDR_W = 16;

	// Action jumper codes
	localparam logic [1:0] PRWDT_ACT_RESET = 2'h0;
	localparam logic [1:0] PRWDT_ACT_NMI = 2'h1;
	localparam logic [1:0] PRWDT_ACT_OFF = 2'h2;

	// Period jumper codes, bit0=5-6 bit1=7-8 bit2=9-10, 1 = open
	localparam logic [2:0] PRWDT_JP_1S = 3'h0;
	localparam logic [2:0] PRWDT_JP_2S = 3'h1;
	localparam logic [2:0] PRWDT_JP_10S = 3'h2;
	localparam logic [2:0] PRWDT_JP_20S = 3'h3;
	localparam logic [2:0] PRWDT_JP_110S = 3'h4;
	localparam logic [2:0] PRWDT_JP_220S = 3'h5;

	localparam int unsigned PRWDT_CLK_HZ = 10000000;
	localparam int unsigned PRWDT_TICK_CYCLES = PRWDT_CLK_HZ;
	localparam logic [7:0] PRWDT_SEC_1 = 8'h01;
	localparam logic [7:0] PRWDT_SEC_2 = 8'h02;
	localparam logic [7:0] PRWDT_SEC_10 = 8'h0A;
	localparam logic [7:0] PRWDT_SEC_20 = 8'h14;
	localparam logic [7:0] PRWDT_SEC_110 = 8'h6E;
	localparam logic [7:0] PRWDT_SEC_220 = 8'hDC;

	localparam logic [7:0] PRWDT_READ_DATA = 8'hFF;

	typedef enum logic [1:0] {
		PRWDT_ST_IDLE  = 2'b01,
		PRWDT_ST_ARMED = 2'b10
	} prwdt_state_t;

endpackage : prwdt_pkg

// ### rtl/prwdt_if.sv
// Interface carrying decoded port commands between decoder and timer
interface prwdt_if;
	logic arm_kick;
	logic disarm;
	modport dec (output arm_kick, output disarm);
	modport tmr (input arm_kick, input disarm);
endinterface : prwdt_if

// ### rtl/prwdt_decode.sv
// I/O port decoder for the watchdog control ports
module prwdt_decode
	import prwdt_pkg::*;
(
	input  wire logic                    sys_clk_i,   // System clock
	input  wire logic                    reset_n_i,   // Sync reset, active low
	input  wire logic [PRWDT_ADDR_W-1:0] io_addr_i,   // I/O address
	input  wire logic                    io_rd_i,     // I/O read strobe, one cycle
	input  wire logic                    io_wr_i,     // I/O write strobe, one cycle
	prwdt_if.dec                         cmd          // Decoded commands
);
	logic arm_kick;
	logic disarm;
	logic next_arm_kick;
	logic next_disarm;

	// Writes never qualify, so they cannot arm, kick or disarm
	always_comb begin
		next_arm_kick = io_rd_i && !io_wr_i && (io_addr_i == PRWDT_ARM_KICK_PORT_ADDR);
		next_disarm   = io_rd_i && !io_wr_i && (io_addr_i == PRWDT_DISARM_PORT_ADDR);
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			arm_kick <= 1'b0;
			disarm   <= 1'b0;
		end else begin
			arm_kick <= next_arm_kick;
			disarm   <= next_disarm;
		end
	end

	assign cmd.arm_kick = arm_kick;
	assign cmd.disarm   = disarm;

endmodule : prwdt_decode

// ### tb/prwdt_asserts.sv
// Port-level checker for the watchdog timer
// --------
// Properties
// --------
module prwdt_asserts
	import prwdt_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 8 // Cycles per second
)(
	input wire logic                    sys_clk_i,               // Clock
	input wire logic                    reset_n_i,               // Reset
	input wire logic [PRWDT_ADDR_W-1:0] io_addr_i,               // Address
	input wire logic                    io_rd_i,                 // Read
	input wire logic                    io_wr_i,                 // Write
	input wire logic [7:0]              io_rdata_o,              // Data
	input wire logic [1:0]              timeout_action_jumper_i, // Action
	input wire logic [2:0]              timeout_period_jumper_i, // Period
	input wire logic                    sys_reset_o,             // Reset out
	input wire logic                    nmi_o,                   // NMI out
	input wire logic                    armed_o                  // Armed
);
	timeunit 1ns;
	timeprecision 1ns;
	int   cnt;
	logic kick;
	logic hit;
	assign kick = io_rd_i && !io_wr_i && io_addr_i == PRWDT_ARM_KICK_PORT_ADDR;
	assign hit = sys_reset_o || nmi_o;
	// Fewest cycles from a kick to its timeout; unlisted codes act as 1 s
	function automatic int unsigned min_span(input logic [2:0] code);
		case (code)
			PRWDT_JP_2S:   min_span = TICK_CYCLES * PRWDT_SEC_2;
			PRWDT_JP_10S:  min_span = TICK_CYCLES * PRWDT_SEC_10;
			PRWDT_JP_20S:  min_span = TICK_CYCLES * PRWDT_SEC_20;
			PRWDT_JP_110S: min_span = TICK_CYCLES * PRWDT_SEC_110;
			PRWDT_JP_220S: min_span = TICK_CYCLES * PRWDT_SEC_220;
			default:       min_span = TICK_CYCLES * PRWDT_SEC_1;
		endcase
	endfunction : min_span
	// Cycles since the last kick, so a too early timeout shows
	always_ff @(posedge sys_clk_i) cnt <= (!reset_n_i || kick) ? 0 : cnt + 1;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_ARM: assert property (kick && !armed_o |-> ##2 armed_o)
		else $error("arm read did not arm");
	AST_DISARM: assert property (io_rd_i && !io_wr_i &&
		io_addr_i == PRWDT_DISARM_PORT_ADDR |-> ##2 !armed_o) else $error("not disarmed");
	AST_ROSE: assert property ($rose(armed_o) |-> $past(kick, 2))
		else $error("armed without a read");
	// The pulse is registered, so it reflects the jumper one cycle earlier
	AST_OFF: assert property (hit |-> !$past(timeout_action_jumper_i[1]))
		else $error("action while off");
	AST_SEL: assert property (hit |->
		nmi_o == ($past(timeout_action_jumper_i) == PRWDT_ACT_NMI) &&
		sys_reset_o == ($past(timeout_action_jumper_i) == PRWDT_ACT_RESET))
		else $error("wrong action");
	AST_ONE: assert property (hit |=> !hit)
		else $error("pulse too long");
	AST_FALL: assert property (hit |-> !armed_o && $past(armed_o))
		else $error("pulse without armed timer");
	AST_EARLY: assert property (hit |->
		cnt >= min_span($past(timeout_period_jumper_i))) else $error("timeout too early");
endmodule : prwdt_asserts

bind prwdt_top prwdt_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_asserts (.sys_clk_i, .reset_n_i,
	.io_addr_i, .io_rd_i, .io_wr_i, .io_rdata_o, .timeout_action_jumper_i,
	.timeout_period_jumper_i, .sys_reset_o, .nmi_o, .armed_o);

// ### tb/prwdt_host.sv
// Host CPU model issuing I/O cycles
module prwdt_host
	import prwdt_pkg::*;
(
	input  wire logic                    sys_clk_i, // Clock
	output logic      [PRWDT_ADDR_W-1:0] io_addr_o, // Address
	output logic                         io_rd_o,   // Read strobe
	output logic                         io_wr_o    // Write strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		io_addr_o = '0;
		io_rd_o = 1'b0;
		io_wr_o = 1'b0;
	end
	// --------
	// Bus cycle
	// --------
	// Released address is inverted so a stale value never decodes
	task automatic cyc(input logic [PRWDT_ADDR_W-1:0] a, input logic wr);
		@(posedge sys_clk_i);
		io_addr_o <= a;
		io_rd_o <= !wr;
		io_wr_o <= wr;
		@(posedge sys_clk_i);
		io_rd_o <= 1'b0;
		io_wr_o <= 1'b0;
		io_addr_o <= ~a;
	endtask : cyc
endmodule : prwdt_host

// ### tb/tb.sv
// Self-checking bench for the watchdog timer
module tb
	import prwdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned T = 8;
	localparam logic [15:0] ARM = PRWDT_ARM_KICK_PORT_ADDR;
	int                      secs[$] = '{1, 2, 10, 20, 110, 220, 1, 1};
	int                      error_cnt = 0;
	int                      tests_run = 0;
	int                      n;
	logic                    clk, rst_n, rd, wr, sr, nmi, armed;
	logic [PRWDT_ADDR_W-1:0] addr;
	logic [7:0]              rdata;
	logic [1:0]              act = PRWDT_ACT_RESET;
	logic [2:0]              per = PRWDT_JP_1S;
	prwdt_host i_host (.sys_clk_i(clk), .io_addr_o(addr), .io_rd_o(rd), .io_wr_o(wr));
	prwdt_top #(.TICK_CYCLES(T)) i_dut (.sys_clk_i(clk), .reset_n_i(rst_n), .io_addr_i(addr),
		.io_rd_i(rd), .io_wr_i(wr), .io_rdata_o(rdata), .timeout_action_jumper_i(act),
		.timeout_period_jumper_i(per), .sys_reset_o(sr), .nmi_o(nmi), .armed_o(armed));
	task automatic chk(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: flag", $time);
		end
	endtask : chk
	task automatic chk_n(input int got, input int lo);
		tests_run++;
		if (got < lo || got > lo + 3) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: timeout after %0d", $time, got);
		end
	endtask : chk_n
	// Counts cycles until a timeout pulse or the limit
	task automatic watch(input int lim);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (sr !== 1'b1 && nmi !== 1'b1 && n < lim);
	endtask : watch
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// About three times the expected run
	initial begin
		#4000000;
		error_cnt++;
		report_and_stop();
	end
	// --------
	// Stimulus
	// --------
	initial begin
		rst_n = 1'b0;
		n = $urandom(32'hBE18BF38);
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		watch(3 * T);
		chk(armed | sr | nmi, 1'b0);
		chk(rdata == PRWDT_READ_DATA, 1'b1);
		i_host.cyc(ARM, 1'b1);
		i_host.cyc(ARM ^ 16'h0100, 1'b0);
		watch(2);
		chk(armed, 1'b0);
		for (int a = 0; a < 4; a++) begin
			for (int p = 0; p < 8; p++) begin
				@(posedge clk);
				act <= a[1:0];
				per <= p[2:0];
				i_host.cyc(ARM, 1'b0);
				watch(secs[p] * T + 8);
				if (a < 2)
					chk_n(n, secs[p] * T);
				chk(sr, a == 0);
				chk(nmi, a == 1);
				i_host.cyc(PRWDT_DISARM_PORT_ADDR, 1'b0);
			end
		end
		@(posedge clk);
		act <= PRWDT_ACT_NMI;
		per <= PRWDT_JP_2S;
		i_host.cyc(ARM, 1'b0);
		repeat (6) begin
			watch($urandom_range(2 * T - 4, 2));
			chk(nmi, 1'b0);
			i_host.cyc(ARM, 1'b0);
		end
		watch(2 * T + 8);
		chk_n(n, 2 * T);
		chk(nmi, 1'b1);
		i_host.cyc(ARM, 1'b0);
		i_host.cyc(PRWDT_DISARM_PORT_ADDR, 1'b1);
		watch(2);
		chk(armed, 1'b1);
		i_host.cyc(PRWDT_DISARM_PORT_ADDR, 1'b0);
		watch(3 * T);
		chk(armed | sr | nmi, 1'b0);
		report_and_stop();
	end
endmodule : tb
